/* logic/smrs_reset_ctrl.sv */
// Function
// - Supply below threshold drives reset pin low and holds core until it recovers.
// - Monitor enabled at power-on; enable survives every other reset.
// - Flash write or erase without high, enabled, selected monitor causes flash-error reset.
// - Monitor reset releases without the power-on delay.
// - High threshold with low supply after non-power-on reset keeps device in reset.
// - Power-on reset returns the threshold select to the low threshold.
// - Control bit 7 turns monitor on; resets only when also selected as source.
// - Control bit 6 reads live monitor output, one when supply above threshold.
// - Control bit 5 selects low (0) or high (1) threshold.
// - Control bits 4 to 0 read zero and ignore writes.
// - Leaving a pin reset sets the pin flag, bit 0.
// - Missing-clock one-shot retriggered by clock edges resets on timeout.
// - Missing-clock flag, bit 2, reads one after missing-clock reset only.
// - Writing bit 2 enables (1) or disables (0) the missing-clock detector.
// - Missing-clock reset leaves the reset pin undriven.
// - Power-on sets the power-on flag and clears the pin, missing-clock and flash-error flags.
`timescale 1ns/100ps
`include "smrs_params.svh"
module smrs_reset_ctrl #(
    parameter int unsigned POR_DELAY_CYC = (`SMRS_POR_DELAY_NS + `SMRS_CLK_PERIOD_NS - 1)
                                           / `SMRS_CLK_PERIOD_NS,
    parameter int unsigned MCD_CYC       = (`SMRS_MCD_TIMEOUT_NS + `SMRS_CLK_PERIOD_NS - 1)
                                           / `SMRS_CLK_PERIOD_NS
) (
    // Clock and power-on reset.
    input  wire logic                   core_clk_i,
    input  wire logic                   rst_n_i,
    // Special-function register access.
    input  wire smrs_pkg::smrs_sfr_req_s sfr_req_i,
    output logic [7:0]                  sfr_rdata_o,
    // Analog supply monitor.
    input  wire logic                   vdd_above_i,
    output logic                        monitor_on_o,
    output logic                        threshold_high_o,
    // Watched system clock level and flash activity.
    input  wire logic                   sysclk_lvl_i,
    input  wire logic                   flash_wr_erase_i,
    // Open-drain reset pin.
    input  wire logic                   rst_pin_n_i,
    output logic                        rst_pin_o,
    output logic                        rst_pin_oe_o,
    // Core reset.
    output logic                        core_rst_n_o
);
    // Both counts must fit the 12-bit timers below.
    if (POR_DELAY_CYC < 1 || POR_DELAY_CYC > 4095 || MCD_CYC < 2 || MCD_CYC > 4095) begin
        $error("smrs_reset_ctrl: timing counts out of range.");
    end

    smrs_pkg::smrs_state_e state_reg, state_next;
    smrs_pkg::smrs_cause_e cause_reg, cause_next;
    logic       mon_en_reg, mon_en_next;
    logic       lvl_reg, lvl_next;
    logic       mon_src_reg, mon_src_next;
    logic       mcd_en_reg, mcd_en_next;
    logic       pin_f_reg, pin_f_next;
    logic       por_f_reg, por_f_next;
    logic       mcd_f_reg, mcd_f_next;
    logic       ferr_f_reg, ferr_f_next;
    logic       core_rst_n_reg, core_rst_n_next;
    logic       oe_reg, oe_next;
    logic [7:0] rdata_reg, rdata_next;
    logic       sysclk_q_reg;
    logic       por_done;
    logic       mcd_expired;
    logic       mon_active;
    logic       pin_active;
    logic       mcd_active;
    logic       ferr_hit;
    logic       sw_ok;

    smrs_timeout #(.LIMIT(POR_DELAY_CYC), .W(12)) u_por_delay (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .restart_i  (state_reg != smrs_pkg::SMRS_ST_POR),
        .expired_o  (por_done)
    );

    // Edges of the watched clock retrigger the one-shot; a disabled detector is held idle.
    smrs_timeout #(.LIMIT(MCD_CYC - 1), .W(12)) u_mcd (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .restart_i  (!mcd_en_reg || (sysclk_lvl_i != sysclk_q_reg)),
        .expired_o  (mcd_expired)
    );

    always_comb begin
        mon_active = mon_en_reg && mon_src_reg && !vdd_above_i;
        pin_active = !rst_pin_n_i && !oe_reg;
        mcd_active = mcd_en_reg && mcd_expired;
        sw_ok      = core_rst_n_reg && (state_reg == smrs_pkg::SMRS_ST_RUN);
        ferr_hit   = sw_ok && flash_wr_erase_i
                     && !(mon_en_reg && lvl_reg && mon_src_reg);
    end

    always_comb begin
        state_next      = state_reg;
        cause_next      = cause_reg;
        mon_en_next     = mon_en_reg;
        lvl_next        = lvl_reg;
        mon_src_next    = mon_src_reg;
        mcd_en_next     = mcd_en_reg;
        pin_f_next      = pin_f_reg;
        por_f_next      = por_f_reg;
        mcd_f_next      = mcd_f_reg;
        ferr_f_next     = ferr_f_reg;
        core_rst_n_next = core_rst_n_reg;
        oe_next         = oe_reg;
        rdata_next      = 8'h00;
        case (state_reg)
            smrs_pkg::SMRS_ST_POR: begin
                core_rst_n_next = 1'b0;
                oe_next         = 1'b1;
                if (por_done && (vdd_above_i || !mon_en_reg)) begin
                    state_next      = smrs_pkg::SMRS_ST_RUN;
                    core_rst_n_next = 1'b1;
                    oe_next         = 1'b0;
                    por_f_next      = 1'b1;
                    pin_f_next      = 1'b0;
                    mcd_f_next      = 1'b0;
                    ferr_f_next     = 1'b0;
                end
            end
            smrs_pkg::SMRS_ST_RUN: begin
                if (mon_active || pin_active || mcd_active || ferr_hit) begin
                    state_next      = smrs_pkg::SMRS_ST_HOLD;
                    core_rst_n_next = 1'b0;
                    if (mon_active) begin
                        cause_next = smrs_pkg::SMRS_CAUSE_MON;
                        oe_next    = 1'b1;
                    end else if (pin_active) begin
                        cause_next = smrs_pkg::SMRS_CAUSE_PIN;
                    end else if (mcd_active) begin
                        cause_next = smrs_pkg::SMRS_CAUSE_MCD;
                    end else begin
                        cause_next = smrs_pkg::SMRS_CAUSE_FERR;
                    end
                end
            end
            smrs_pkg::SMRS_ST_HOLD: begin
                oe_next = mon_active;
                if (!mon_active && !pin_active && !mcd_active) begin
                    // No power-on delay here, whatever the cause.
                    state_next      = smrs_pkg::SMRS_ST_RUN;
                    core_rst_n_next = 1'b1;
                    oe_next         = 1'b0;
                    por_f_next  = (cause_reg == smrs_pkg::SMRS_CAUSE_MON);
                    pin_f_next  = (cause_reg == smrs_pkg::SMRS_CAUSE_PIN);
                    mcd_f_next  = (cause_reg == smrs_pkg::SMRS_CAUSE_MCD);
                    ferr_f_next = (cause_reg == smrs_pkg::SMRS_CAUSE_FERR);
                end
            end
            default: begin
                state_next = smrs_pkg::SMRS_ST_POR;
            end
        endcase
        // Software can only write the registers while the core runs; reads are served at any time.
        if (sw_ok && sfr_req_i.wr && !ferr_hit) begin
            if (sfr_req_i.addr == `SMRS_ADDR_CTRL) begin
                mon_en_next = sfr_req_i.wdata[`SMRS_CTRL_EN_BIT];
                lvl_next    = sfr_req_i.wdata[`SMRS_CTRL_LVL_BIT];
            end else if (sfr_req_i.addr == `SMRS_ADDR_RESET_SOURCE_REGISTER) begin
                if (sfr_req_i.wdata[`SMRS_SRC_POR_BIT]) begin
                    mon_src_next = 1'b1;
                end
                mcd_en_next = sfr_req_i.wdata[`SMRS_SRC_MCD_BIT];
            end
        end
        if (sfr_req_i.rd) begin
            if (sfr_req_i.addr == `SMRS_ADDR_CTRL) begin
                rdata_next[`SMRS_CTRL_EN_BIT]   = mon_en_reg;
                rdata_next[`SMRS_CTRL_STAT_BIT] = vdd_above_i;
                rdata_next[`SMRS_CTRL_LVL_BIT]  = lvl_reg;
            end else if (sfr_req_i.addr == `SMRS_ADDR_RESET_SOURCE_REGISTER) begin
                rdata_next[`SMRS_SRC_PIN_BIT]  = pin_f_reg;
                rdata_next[`SMRS_SRC_POR_BIT]  = por_f_reg;
                rdata_next[`SMRS_SRC_MCD_BIT]  = mcd_f_reg;
                rdata_next[`SMRS_SRC_FERR_BIT] = ferr_f_reg;
            end
        end
    end

    // Only the power-on reset touches enable, level and source selection.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg      <= smrs_pkg::SMRS_ST_POR;
            cause_reg      <= smrs_pkg::SMRS_CAUSE_NONE;
            mon_en_reg     <= `SMRS_CTRL_EN_RST;
            lvl_reg        <= `SMRS_CTRL_LVL_RST;
            mon_src_reg    <= `SMRS_MON_SEL_RST;
            mcd_en_reg     <= `SMRS_MCD_EN_RST;
            pin_f_reg      <= 1'b0;
            por_f_reg      <= 1'b0;
            mcd_f_reg      <= 1'b0;
            ferr_f_reg     <= 1'b0;
            core_rst_n_reg <= 1'b0;
            oe_reg         <= 1'b1;
            rdata_reg      <= 8'h00;
            sysclk_q_reg   <= 1'b0;
        end else begin
            state_reg      <= state_next;
            cause_reg      <= cause_next;
            mon_en_reg     <= mon_en_next;
            lvl_reg        <= lvl_next;
            mon_src_reg    <= mon_src_next;
            mcd_en_reg     <= mcd_en_next;
            pin_f_reg      <= pin_f_next;
            por_f_reg      <= por_f_next;
            mcd_f_reg      <= mcd_f_next;
            ferr_f_reg     <= ferr_f_next;
            core_rst_n_reg <= core_rst_n_next;
            oe_reg         <= oe_next;
            rdata_reg      <= rdata_next;
            sysclk_q_reg   <= sysclk_lvl_i;
        end
    end

    always_comb begin
        sfr_rdata_o      = rdata_reg;
        monitor_on_o     = mon_en_reg;
        threshold_high_o = lvl_reg;
        rst_pin_o        = 1'b0;
        rst_pin_oe_o     = oe_reg;
        core_rst_n_o     = core_rst_n_reg;
    end
endmodule

/* inc/smrs_params.svh */
`ifndef SMRS_PARAMS_SVH
`define SMRS_PARAMS_SVH

`define SMRS_ADDR_CTRL        8'hFF
`define SMRS_ADDR_RESET_SOURCE_REGISTER      8'hEF

`define SMRS_CTRL_EN_BIT      7
`define SMRS_CTRL_STAT_BIT    6
`define SMRS_CTRL_LVL_BIT     5
`define SMRS_CTRL_EN_RST      1'b1
`define SMRS_CTRL_LVL_RST     1'b0
`define SMRS_MON_SEL_RST      1'b1
`define SMRS_MCD_EN_RST       1'b0

`define SMRS_SRC_PIN_BIT      0
`define SMRS_SRC_POR_BIT      1
`define SMRS_SRC_MCD_BIT      2
`define SMRS_SRC_FERR_BIT     6

`define SMRS_CLK_PERIOD_NS    25
`define SMRS_MCD_TIMEOUT_NS   100000
`define SMRS_POR_DELAY_NS     10000

`endif

/* inc/smrs_pkg.sv */
package smrs_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } smrs_sfr_req_s;

    typedef enum logic [2:0] {
        SMRS_CAUSE_NONE,
        SMRS_CAUSE_MON,
        SMRS_CAUSE_PIN,
        SMRS_CAUSE_MCD,
        SMRS_CAUSE_FERR
    } smrs_cause_e;

    typedef enum logic [1:0] {
        SMRS_ST_POR,
        SMRS_ST_RUN,
        SMRS_ST_HOLD
    } smrs_state_e;

endpackage

/* logic/smrs_timeout.sv */
`timescale 1ns/100ps
module smrs_timeout #(
    parameter int unsigned LIMIT = 4000,
    parameter int unsigned W     = 12
) (
    // Clock and reset.
    input  wire logic core_clk_i,
    input  wire logic rst_n_i,
    // Control and result.
    input  wire logic restart_i,
    output logic      expired_o
);
    // Refused at elaboration, so a bad count never reaches silicon.
    if (LIMIT < 1 || LIMIT >= (2 ** W)) begin
        $error("smrs_timeout: LIMIT does not fit the counter width.");
    end

    localparam logic [W-1:0] LAST = W'(LIMIT - 1);

    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    logic         exp_reg;
    logic         exp_next;

    // The count saturates so a stopped clock keeps the timeout asserted.
    always_comb begin
        cnt_next = cnt_reg;
        exp_next = exp_reg;
        if (restart_i) begin
            cnt_next = '0;
            exp_next = 1'b0;
        end else if (cnt_reg == LAST) begin
            exp_next = 1'b1;
        end else begin
            cnt_next = cnt_reg + W'(1);
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg <= '0;
            exp_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            exp_reg <= exp_next;
        end
    end

    assign expired_o = exp_reg;
endmodule

/* bench/smrs_supply_model.sv */
`timescale 1ns/100ps
module smrs_supply_model (
    // Design side.
    input  wire logic       pin_oe_i,
    input  wire logic       threshold_high_i,
    // Test control.
    input  wire logic       ext_low_i,
    input  wire logic [1:0] supply_lvl_i,
    // Sensed levels.
    output logic            rst_pin_n_o,
    output logic            vdd_above_o
);
    // The pull-up holds the pin high unless a party pulls it low.
    assign rst_pin_n_o = !(pin_oe_i || ext_low_i);
    // Level 2 clears both thresholds, level 1 only the low one.
    assign vdd_above_o = threshold_high_i ? (supply_lvl_i == 2'h2) : (supply_lvl_i != 2'h0);
endmodule

/* bench/smrs_reset_ctrl_properties.sv */
`timescale 1ns/100ps
`include "smrs_params.svh"
module smrs_reset_ctrl_properties (
    // Clock and reset.
    input wire logic                    core_clk_i,
    input wire logic                    rst_n_i,
    // Register access.
    input wire smrs_pkg::smrs_sfr_req_s sfr_req_i,
    input wire logic [7:0]              sfr_rdata_o,
    // Monitor, flash and pin.
    input wire logic                    vdd_above_i,
    input wire logic                    monitor_on_o,
    input wire logic                    threshold_high_o,
    input wire logic                    flash_wr_erase_i,
    input wire logic                    rst_pin_n_i,
    input wire logic                    rst_pin_o,
    input wire logic                    rst_pin_oe_o,
    input wire logic                    core_rst_n_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    a_pin_data_low: assert property (rst_pin_o == 1'b0)
        else $error("reset pin data not low");
    a_mon_reset: assert property (core_rst_n_o && monitor_on_o && !vdd_above_i
        |=> !core_rst_n_o && rst_pin_oe_o) else $error("monitor reset missed");
    a_pin_hold: assert property (!rst_pin_n_i && !rst_pin_oe_o |=> !core_rst_n_o)
        else $error("pin low did not hold core");
    a_oe_cause: assert property ($rose(rst_pin_oe_o)
        |-> $past(monitor_on_o && !vdd_above_i)) else $error("pin driven without monitor");
    a_ctrl_read: assert property (sfr_req_i.rd && sfr_req_i.addr == `SMRS_ADDR_CTRL
        |=> sfr_rdata_o == {$past(monitor_on_o), $past(vdd_above_i), $past(threshold_high_o),
        5'h00}) else $error("control read wrong");
    a_ctrl_write: assert property (core_rst_n_o && sfr_req_i.wr && !flash_wr_erase_i
        && sfr_req_i.addr == `SMRS_ADDR_CTRL |=> monitor_on_o == $past(sfr_req_i.wdata[7])
        && threshold_high_o == $past(sfr_req_i.wdata[5])) else $error("control write lost");
    a_por_values: assert property ($rose(rst_n_i)
        |-> monitor_on_o && !threshold_high_o) else $error("power-on values wrong");
    a_flash_err: assert property (core_rst_n_o && flash_wr_erase_i
        && !(monitor_on_o && threshold_high_o) |=> !core_rst_n_o) else $error("no flash reset");
endmodule
bind smrs_reset_ctrl smrs_reset_ctrl_properties smrs_reset_ctrl_properties_inst (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .sfr_req_i(sfr_req_i),
    .sfr_rdata_o(sfr_rdata_o), .vdd_above_i(vdd_above_i), .monitor_on_o(monitor_on_o),
    .threshold_high_o(threshold_high_o), .flash_wr_erase_i(flash_wr_erase_i),
    .rst_pin_n_i(rst_pin_n_i), .rst_pin_o(rst_pin_o), .rst_pin_oe_o(rst_pin_oe_o),
    .core_rst_n_o(core_rst_n_o));

/* bench/smrs_reset_ctrl_tb_top.sv */
`timescale 1ns/100ps
`include "smrs_params.svh"
module smrs_reset_ctrl_tb_top;
    logic                    core_clk_i = 1'b0;
    logic                    rst_n_i    = 1'b0;
    smrs_pkg::smrs_sfr_req_s req        = '0;
    logic                    sys_lvl    = 1'b0;
    logic                    sys_run    = 1'b1;
    logic                    flash      = 1'b0;
    logic                    ext_low    = 1'b0;
    logic [1:0]              supply     = 2'h2;
    logic [7:0]              rdata;
    logic [7:0]              rd_v;
    logic                    vdd_above, mon_on, lvl_hi, pin_n, pin_d, pin_oe, core_n;
    int                      n_mismatch = 0;
    int                      tests_run  = 0;
    always #12.5 core_clk_i = ~core_clk_i;
    always @(negedge core_clk_i) if (sys_run) sys_lvl <= ~sys_lvl;
    smrs_reset_ctrl #(.POR_DELAY_CYC(4), .MCD_CYC(8)) smrs_reset_ctrl_inst (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .sfr_req_i(req), .sfr_rdata_o(rdata),
        .vdd_above_i(vdd_above), .monitor_on_o(mon_on), .threshold_high_o(lvl_hi),
        .sysclk_lvl_i(sys_lvl), .flash_wr_erase_i(flash), .rst_pin_n_i(pin_n),
        .rst_pin_o(pin_d), .rst_pin_oe_o(pin_oe), .core_rst_n_o(core_n));
    smrs_supply_model smrs_supply_model_inst (.pin_oe_i(pin_oe), .threshold_high_i(lvl_hi),
        .ext_low_i(ext_low), .supply_lvl_i(supply), .rst_pin_n_o(pin_n), .vdd_above_o(vdd_above));
    task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic sfr(input logic [7:0] addr, input logic wr, input logic [7:0] d);
        @(negedge core_clk_i);
        req <= '{addr: addr, wr: wr, rd: !wr, wdata: d};
        @(negedge core_clk_i);
        rd_v = rdata;
        req <= '0;
    endtask
    task automatic wait_core(input logic exp, input int n, input string name);
        int i;
        for (i = 0; i < n && core_n !== exp; i++) @(negedge core_clk_i);
        check(name, {7'h00, core_n}, {7'h00, exp});
    endtask
    // Counts every cycle, so a one-cycle glitch is caught as well.
    task automatic stay(input logic exp, input int n, input string name);
        logic ok;
        ok = 1'b1;
        repeat (n) begin
            @(negedge core_clk_i);
            ok &= (core_n === exp);
        end
        check(name, {7'h00, ok}, 8'h01);
    endtask
    task automatic pulse_flash;
        @(negedge core_clk_i);
        flash <= 1'b1;
        @(negedge core_clk_i);
        flash <= 1'b0;
    endtask
    task automatic t_por;
        wait_core(1'b1, 20, "core release");
        sfr(`SMRS_ADDR_CTRL, 1'b0, 8'h00);
        check("ctrl", rd_v, 8'hC0);
        sfr(`SMRS_ADDR_RESET_SOURCE_REGISTER, 1'b0, 8'h00);
        check("flags", rd_v, 8'h02);
        check("outputs", {5'h00, pin_d, mon_on, lvl_hi}, 8'h02);
        sfr(8'h10, 1'b0, 8'h00);
        check("unmapped", rd_v, 8'h00);
        $display("Test por done");
    endtask
    task automatic t_ctrl;
        sfr(`SMRS_ADDR_CTRL, 1'b1, 8'hBF);
        sfr(`SMRS_ADDR_CTRL, 1'b0, 8'h00);
        check("ctrl high", rd_v, 8'hE0);
        check("level out", {7'h00, lvl_hi}, 8'h01);
        sfr(`SMRS_ADDR_CTRL, 1'b1, 8'h1F);
        sfr(`SMRS_ADDR_CTRL, 1'b0, 8'h00);
        check("ctrl off", rd_v, 8'h40);
        supply <= 2'h0;
        stay(1'b1, 10, "monitor off");
        sfr(`SMRS_ADDR_CTRL, 1'b0, 8'h00);
        check("status low", rd_v, 8'h00);
        supply <= 2'h2;
        sfr(`SMRS_ADDR_CTRL, 1'b1, 8'h80);
        sfr(`SMRS_ADDR_RESET_SOURCE_REGISTER, 1'b1, 8'h02);
        $display("Test ctrl done");
    endtask
    task automatic t_mon;
        supply <= 2'h0;
        wait_core(1'b0, 3, "monitor reset");
        check("pin driven", {7'h00, pin_n}, 8'h00);
        supply <= 2'h2;
        wait_core(1'b1, 2, "quick release");
        sfr(`SMRS_ADDR_RESET_SOURCE_REGISTER, 1'b0, 8'h00);
        check("monitor flag", rd_v, 8'h02);
        $display("Test mon done");
    endtask
    task automatic t_pin;
        ext_low <= 1'b1;
        wait_core(1'b0, 3, "pin reset");
        ext_low <= 1'b0;
        wait_core(1'b1, 3, "pin release");
        sfr(`SMRS_ADDR_RESET_SOURCE_REGISTER, 1'b0, 8'h00);
        check("pin flag", rd_v, 8'h01);
        $display("Test pin done");
    endtask
    task automatic t_mcd;
        sfr(`SMRS_ADDR_RESET_SOURCE_REGISTER, 1'b1, 8'h04);
        sys_run <= 1'b0;
        wait_core(1'b0, 12, "clock lost");
        check("pin left", {7'h00, pin_oe}, 8'h00);
        sys_run <= 1'b1;
        wait_core(1'b1, 12, "clock back");
        sfr(`SMRS_ADDR_RESET_SOURCE_REGISTER, 1'b0, 8'h00);
        check("clock flag", rd_v, 8'h04);
        sfr(`SMRS_ADDR_RESET_SOURCE_REGISTER, 1'b1, 8'h00);
        sys_run <= 1'b0;
        stay(1'b1, 20, "detector off");
        sys_run <= 1'b1;
        $display("Test mcd done");
    endtask
    task automatic t_flash;
        sfr(`SMRS_ADDR_CTRL, 1'b1, 8'h00);
        pulse_flash();
        wait_core(1'b0, 3, "flash reset");
        wait_core(1'b1, 4, "flash release");
        sfr(`SMRS_ADDR_CTRL, 1'b0, 8'h00);
        check("ctrl kept", rd_v, 8'h40);
        sfr(`SMRS_ADDR_RESET_SOURCE_REGISTER, 1'b0, 8'h00);
        check("flash flag", rd_v, 8'h40);
        sfr(`SMRS_ADDR_CTRL, 1'b1, 8'hA0);
        pulse_flash();
        stay(1'b1, 6, "flash allowed");
        sfr(`SMRS_ADDR_CTRL, 1'b1, 8'h80);
        $display("Test flash done");
    endtask
    task automatic t_hold;
        sfr(`SMRS_ADDR_CTRL, 1'b1, 8'hA0);
        ext_low <= 1'b1;
        supply <= 2'h1;
        wait_core(1'b0, 3, "pin reset");
        ext_low <= 1'b0;
        stay(1'b0, 20, "held low");
        rst_n_i <= 1'b0;
        repeat (2) @(negedge core_clk_i);
        rst_n_i <= 1'b1;
        wait_core(1'b1, 20, "power-on exit");
        sfr(`SMRS_ADDR_CTRL, 1'b0, 8'h00);
        check("low level", rd_v, 8'hC0);
        supply <= 2'h2;
        $display("Test hold done");
    endtask
    task automatic report_and_stop;
        $display("Comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge core_clk_i);
        rst_n_i <= 1'b1;
        t_por();
        t_ctrl();
        t_mon();
        t_pin();
        t_mcd();
        t_flash();
        t_hold();
        report_and_stop();
    end
    initial begin
        repeat (3000) @(posedge core_clk_i);
        n_mismatch++;
        report_and_stop();
    end
endmodule
